// *** design/cvfm_pkg.sv ***
package cvfm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int NCELL = 12;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int VAL_W = 14;
    localparam int TOT_W = 3;
    localparam int CNT_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_OV_LIMIT = 4'h0;
    localparam logic [3:0] ADDR_UV_LIMIT = 4'h1;
    localparam logic [3:0] ADDR_FAULT_SETUP = 4'h2;
    localparam logic [3:0] ADDR_CELL_SETUP = 4'h3;
    localparam logic [3:0] ADDR_OV_FAULT = 4'h4;
    localparam logic [3:0] ADDR_UV_FAULT = 4'h5;
    localparam logic [3:0] ADDR_FAULT_STATUS = 4'h6;

    // ------------------------------------------------------------
    // Reset values and scale
    // ------------------------------------------------------------
    localparam logic [13:0] FULL_SCALE_CODE = 14'h1FFF;
    localparam logic [13:0] OV_LIMIT_RST = 14'h1FFF;
    localparam logic [13:0] UV_LIMIT_RST = 14'h0000;
    localparam logic [2:0] TOT_RST = 3'h3;
    localparam logic [2:0] TOT_TOGGLE = 3'h1;

    // ------------------------------------------------------------
    // Summary fault status bit positions
    // ------------------------------------------------------------
    localparam int ST_OV = 0;
    localparam int ST_UV = 1;
    localparam int ST_OSC = 2;
    localparam int ST_PAR = 3;

    // Sample count select is a power of two
    function automatic logic [7:0] tot_to_count(input logic [2:0] sel);
        tot_to_count = 8'h01 << sel;
    endfunction

endpackage

// *** design/cvfm_link_if.sv ***
`timescale 1ns/1ps
interface cvfm_link_if;
    logic req_valid;
    logic req_write;
    logic [3:0] req_addr;
    logic [15:0] req_wdata;
    logic req_ready;
    logic rsp_valid;
    logic rsp_unsol;
    logic [15:0] rsp_data;
    logic sleep_cmd;
    logic wake_cmd;
    logic comm_fail;

    modport dev (
        input req_valid, req_write, req_addr, req_wdata, sleep_cmd,
        input wake_cmd,
        output req_ready, rsp_valid, rsp_unsol, rsp_data, comm_fail
    );
    modport host (
        output req_valid, req_write, req_addr, req_wdata, sleep_cmd,
        output wake_cmd,
        input req_ready, rsp_valid, rsp_unsol, rsp_data, comm_fail
    );
endinterface

// *** design/cvfm_fault_filter.sv ***
`timescale 1ns/1ps
module cvfm_fault_filter #(
    parameter int N = 12,
    parameter int CW = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Filter control
    input wire logic clear,
    input wire logic [N-1:0] sample,
    input wire logic [N-1:0] result,
    input wire logic [CW-1:0] target,
    // Qualified fault
    output logic [N-1:0] hit
);

    typedef struct packed {
        logic [N-1:0][CW-1:0] cnt;
    } cvfm_filt_state_t;

    cvfm_filt_state_t q;
    cvfm_filt_state_t s;

    // ------------------------------------------------------------
    // Totalizing counters
    // ------------------------------------------------------------
    // Counters saturate at the target so the increment never wraps
    always_comb begin
        s = q;
        hit = '0;
        for (int i = 0; i < N; i++) begin
            if (clear) begin
                s.cnt[i] = '0;
            end else if (sample[i]) begin
                if (!result[i]) begin
                    s.cnt[i] = '0;
                end else begin
                    hit[i] = (q.cnt[i] + 1'b1) >= target;
                    if (q.cnt[i] < target) begin
                        s.cnt[i] = q.cnt[i] + 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= s;
        end
    end

endmodule // cvfm_fault_filter

// *** design/cvfm_device.sv ***
// Notes on behaviour
// - Monitored functions set summary status bits
// - Oscillator fault: flag first, then sleep
// - Asleep device ignores normal link traffic
// - Host recovers with repeated sleep/wake commands
// - Limits share 14-bit cell scale, 1FFF=5V
// - Sample count select resets to 011
// - Cell setup bit 0 connected, 1 absent
// - Unconnected inputs never raise overvoltage
// - Overvoltage after programmed unbroken positive run
// - Status pushed unasked when leaving zero
// - Host reads overvoltage register only on fault
// - Host clears cell flags, then status
// - Select change resets filters; host toggles it
// - Negative overvoltage result clears its filter
// - Undervoltage: connected only, filtered likewise
// - Select decodes to 1 shifted by code
// - Sample on scan end or single measure
`timescale 1ns/1ps
module cvfm_device #(
    parameter int N = cvfm_pkg::NCELL
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host link
    cvfm_link_if.dev link,
    // Measurement results
    input wire logic [N*14-1:0] cell_value,
    input wire logic scan_done,
    input wire logic meas_done,
    input wire logic [3:0] meas_cell,
    // Internal function monitors
    input wire logic osc_fault,
    input wire logic par_fault,
    // Status view
    output logic [N-1:0] ov_fault_flags,
    output logic [N-1:0] uv_fault_flags,
    output logic [15:0] fault_status,
    output logic asleep
);

    typedef struct packed {
        logic [13:0] ov_lim;
        logic [13:0] uv_lim;
        logic [2:0] tot;
        logic [N-1:0] cell_off;
        logic [N-1:0] ov_flt;
        logic [N-1:0] uv_flt;
        logic [15:0] status;
        logic asleep;
        logic rsp_valid;
        logic rsp_unsol;
        logic [15:0] rsp_data;
    } cvfm_dev_state_t;

    cvfm_dev_state_t q;
    cvfm_dev_state_t s;

    logic acc;
    logic wr;
    logic rd;
    logic filt_clr;
    logic unsol_now;
    logic [N-1:0] sample;
    logic [N-1:0] onehot;
    logic [N-1:0] ov_res;
    logic [N-1:0] uv_res;
    logic [N-1:0] ov_hit;
    logic [N-1:0] uv_hit;
    logic [15:0] evt;
    logic [7:0] target;

    // ------------------------------------------------------------
    // Link handshake
    // ------------------------------------------------------------
    // Ready drops for an unsolicited push so a read answer never
    // collides with it on the shared response lines
    assign unsol_now = !q.asleep && (q.status == 16'h0000)
        && (evt != 16'h0000);
    assign link.req_ready = !q.asleep && !unsol_now;
    assign acc = link.req_valid && link.req_ready;
    assign wr = acc && link.req_write;
    assign rd = acc && !link.req_write;
    assign link.rsp_valid = q.rsp_valid;
    assign link.rsp_unsol = q.rsp_unsol;
    assign link.rsp_data = q.rsp_data;
    assign link.comm_fail = q.asleep;

    // ------------------------------------------------------------
    // Sampling and comparison
    // ------------------------------------------------------------
    assign onehot = {{(N-1){1'b0}}, 1'b1} << meas_cell;
    // No sampling while asleep: the measurement side is halted
    assign sample = q.asleep ? '0 :
        (scan_done ? '1 : (meas_done ? onehot : '0));

    for (genvar i = 0; i < N; i++) begin : g_cmp
        logic [13:0] v;
        assign v = cell_value[i*14 +: 14];
        // A set cell setup bit means no cell on this input
        assign ov_res[i] = !q.cell_off[i] && (v > q.ov_lim);
        assign uv_res[i] = !q.cell_off[i] && (v < q.uv_lim);
    end

    assign target = cvfm_pkg::tot_to_count(q.tot);
    assign filt_clr = wr && (link.req_addr == cvfm_pkg::ADDR_FAULT_SETUP)
        && (link.req_wdata[2:0] != q.tot);

    cvfm_fault_filter #(
        .N(N),
        .CW(cvfm_pkg::CNT_W)
    ) u_ov_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(filt_clr),
        .sample(sample),
        .result(ov_res),
        .target(target),
        .hit(ov_hit)
    );

    cvfm_fault_filter #(
        .N(N),
        .CW(cvfm_pkg::CNT_W)
    ) u_uv_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .clear(filt_clr),
        .sample(sample),
        .result(uv_res),
        .target(target),
        .hit(uv_hit)
    );

    // ------------------------------------------------------------
    // Fault events
    // ------------------------------------------------------------
    always_comb begin
        evt = 16'h0000;
        evt[cvfm_pkg::ST_OV] = |ov_hit;
        evt[cvfm_pkg::ST_UV] = |uv_hit;
        evt[cvfm_pkg::ST_OSC] = osc_fault;
        evt[cvfm_pkg::ST_PAR] = par_fault;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_comb begin
        s = q;
        s.rsp_valid = 1'b0;
        s.rsp_unsol = 1'b0;
        if (wr) begin
            case (link.req_addr)
                cvfm_pkg::ADDR_OV_LIMIT: begin
                    s.ov_lim = link.req_wdata[13:0];
                end
                cvfm_pkg::ADDR_UV_LIMIT: begin
                    s.uv_lim = link.req_wdata[13:0];
                end
                cvfm_pkg::ADDR_FAULT_SETUP: begin
                    s.tot = link.req_wdata[2:0];
                end
                cvfm_pkg::ADDR_CELL_SETUP: begin
                    s.cell_off = link.req_wdata[N-1:0];
                end
                cvfm_pkg::ADDR_OV_FAULT: begin
                    s.ov_flt = link.req_wdata[N-1:0];
                end
                cvfm_pkg::ADDR_UV_FAULT: begin
                    s.uv_flt = link.req_wdata[N-1:0];
                end
                cvfm_pkg::ADDR_FAULT_STATUS: begin
                    s.status = link.req_wdata;
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            s.rsp_valid = 1'b1;
            case (link.req_addr)
                cvfm_pkg::ADDR_OV_LIMIT: s.rsp_data = {2'h0, q.ov_lim};
                cvfm_pkg::ADDR_UV_LIMIT: s.rsp_data = {2'h0, q.uv_lim};
                cvfm_pkg::ADDR_FAULT_SETUP: s.rsp_data = {13'h0000, q.tot};
                cvfm_pkg::ADDR_CELL_SETUP: s.rsp_data = 16'(q.cell_off);
                cvfm_pkg::ADDR_OV_FAULT: s.rsp_data = 16'(q.ov_flt);
                cvfm_pkg::ADDR_UV_FAULT: s.rsp_data = 16'(q.uv_flt);
                cvfm_pkg::ADDR_FAULT_STATUS: s.rsp_data = q.status;
                default: s.rsp_data = 16'h0000;
            endcase
        end
        // Hardware set wins over a host write in the same cycle
        s.ov_flt = s.ov_flt | ov_hit;
        s.uv_flt = s.uv_flt | uv_hit;
        s.status = s.status | evt;
        if (unsol_now) begin
            s.rsp_valid = 1'b1;
            s.rsp_unsol = 1'b1;
            s.rsp_data = s.status;
        end
        if (link.sleep_cmd) begin
            s.asleep = 1'b1;
        end
        if (link.wake_cmd) begin
            s.asleep = 1'b0;
        end
        // Sleep follows only once the flag is already held
        if (osc_fault && q.status[cvfm_pkg::ST_OSC]) begin
            s.asleep = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
            q.ov_lim <= cvfm_pkg::OV_LIMIT_RST;
            q.uv_lim <= cvfm_pkg::UV_LIMIT_RST;
            q.tot <= cvfm_pkg::TOT_RST;
        end else begin
            q <= s;
        end
    end

    // ------------------------------------------------------------
    // Status view
    // ------------------------------------------------------------
    assign ov_fault_flags = q.ov_flt;
    assign uv_fault_flags = q.uv_flt;
    assign fault_status = q.status;
    assign asleep = q.asleep;

endmodule // cvfm_device

// *** design/cvfm_host.sv ***
`timescale 1ns/1ps
module cvfm_host (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Device link
    cvfm_link_if.host link,
    // User command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [3:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    output logic cmd_ready,
    output logic rd_valid,
    output logic [15:0] rd_data,
    // Fault handling requests
    input wire logic clear_faults,
    input wire logic filt_reset,
    input wire logic [2:0] tot_value,
    output logic seq_ready,
    // Fault reports
    output logic alert_valid,
    output logic [15:0] alert_status,
    output logic ov_detail_valid,
    output logic [15:0] ov_detail,
    output logic recovering
);

    typedef enum logic [3:0] {
        H_IDLE, H_REQ, H_WAIT, H_CLR_UV, H_CLR_ST, H_TOT_SET,
        H_REC_SLEEP, H_REC_WAKE, H_REC_CHK
    } cvfm_host_st_t;

    typedef struct packed {
        cvfm_host_st_t st;
        logic write;
        logic [3:0] addr;
        logic [15:0] wdata;
        logic to_user;
        logic want_ov;
        logic rd_valid;
        logic [15:0] rd_data;
        logic alert_valid;
        logic [15:0] alert_status;
        logic ov_valid;
        logic [15:0] ov_data;
    } cvfm_host_state_t;

    cvfm_host_state_t q;
    cvfm_host_state_t s;
    logic sent;
    assign seq_ready = (q.st == H_IDLE) && !link.comm_fail && !q.want_ov;
    assign cmd_ready = seq_ready && !clear_faults && !filt_reset;
    assign link.req_valid = (q.st == H_REQ) || (q.st == H_CLR_UV)
        || (q.st == H_CLR_ST) || (q.st == H_TOT_SET);
    assign link.req_write = q.write;
    assign link.req_addr = q.addr;
    assign link.req_wdata = q.wdata;
    assign link.sleep_cmd = (q.st == H_REC_SLEEP);
    assign link.wake_cmd = (q.st == H_REC_WAKE);
    assign sent = link.req_valid && link.req_ready;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        s = q;
        s.rd_valid = 1'b0;
        s.alert_valid = 1'b0;
        s.ov_valid = 1'b0;
        if (link.rsp_valid && link.rsp_unsol) begin
            s.alert_valid = 1'b1;
            s.alert_status = link.rsp_data;
            // Detail is fetched only when the summary reports it
            s.want_ov = q.want_ov || link.rsp_data[cvfm_pkg::ST_OV];
        end
        unique case (q.st)
            H_IDLE: begin
                s.write = 1'b1;
                s.to_user = 1'b0;
                if (link.comm_fail) begin
                    s.st = H_REC_SLEEP;
                end else if (q.want_ov) begin
                    s.st = H_REQ;
                    s.write = 1'b0;
                    s.addr = cvfm_pkg::ADDR_OV_FAULT;
                    s.want_ov = 1'b0;
                end else if (clear_faults) begin
                    s.st = H_REQ;
                    s.addr = cvfm_pkg::ADDR_OV_FAULT;
                    s.wdata = 16'h0000;
                end else if (filt_reset) begin
                    // A different value first forces the filter reset
                    s.st = H_REQ;
                    s.addr = cvfm_pkg::ADDR_FAULT_SETUP;
                    s.wdata = {13'h0000, tot_value ^ cvfm_pkg::TOT_TOGGLE};
                end else if (cmd_valid) begin
                    s.st = H_REQ;
                    s.write = cmd_write;
                    s.addr = cmd_addr;
                    s.wdata = cmd_wdata;
                    s.to_user = 1'b1;
                end
                if (filt_reset && !link.comm_fail && !q.want_ov
                        && !clear_faults) begin
                    s.rd_data = {13'h0000, tot_value};
                end
            end
            H_REQ: begin
                if (sent) begin
                    if (!q.write) begin
                        s.st = H_WAIT;
                    end else if (!q.to_user
                            && q.addr == cvfm_pkg::ADDR_OV_FAULT) begin
                        s.st = H_CLR_UV;
                        s.addr = cvfm_pkg::ADDR_UV_FAULT;
                    end else if (!q.to_user
                            && q.addr == cvfm_pkg::ADDR_FAULT_SETUP) begin
                        s.st = H_TOT_SET;
                        s.wdata = q.rd_data;
                    end else begin
                        s.st = H_IDLE;
                    end
                end
            end
            H_WAIT: begin
                if (link.rsp_valid && !link.rsp_unsol) begin
                    s.st = H_IDLE;
                    s.rd_valid = q.to_user;
                    s.rd_data = link.rsp_data;
                    s.ov_valid = !q.to_user;
                    s.ov_data = link.rsp_data;
                end
            end
            H_CLR_UV: begin
                if (sent) begin
                    s.st = H_CLR_ST;
                    s.addr = cvfm_pkg::ADDR_FAULT_STATUS;
                end
            end
            H_CLR_ST, H_TOT_SET: begin
                if (sent) begin
                    s.st = H_IDLE;
                end
            end
            H_REC_SLEEP: s.st = H_REC_WAKE;
            H_REC_WAKE: s.st = H_REC_CHK;
            H_REC_CHK: s.st = link.comm_fail ? H_REC_SLEEP : H_IDLE;
        endcase
        // A sleeping device never answers, so any wait is abandoned
        if (link.comm_fail && q.st != H_REC_SLEEP && q.st != H_REC_WAKE
                && q.st != H_REC_CHK) begin
            s.st = H_REC_SLEEP;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '0;
            q.st <= H_IDLE;
        end else begin
            q <= s;
        end
    end

    assign rd_valid = q.rd_valid;
    assign rd_data = q.rd_data;
    assign alert_valid = q.alert_valid;
    assign alert_status = q.alert_status;
    assign ov_detail_valid = q.ov_valid;
    assign ov_detail = q.ov_data;
    assign recovering = (q.st == H_REC_SLEEP) || (q.st == H_REC_WAKE)
        || (q.st == H_REC_CHK);

endmodule // cvfm_host

// *** dv/cvfm_link_checker.sv ***
`timescale 1ns/1ps
module cvfm_link_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Host to device
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [3:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic sleep_cmd,
    input wire logic wake_cmd,
    // Device to host
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_unsol,
    input wire logic [15:0] rsp_data,
    input wire logic comm_fail
);
    // ------------------------------------------------------------
    // Link properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_asleep_refuse: assert property (comm_fail |-> !req_ready)
        else $error("request accepted while asleep");
    a_read_answer: assert property (
        req_valid && req_ready && !req_write |=> rsp_valid)
        else $error("read not answered next cycle");
    a_write_silent: assert property (
        req_valid && req_ready && req_write |=> !rsp_valid || rsp_unsol)
        else $error("write produced an answer");
    a_sleep_enter: assert property (
        sleep_cmd && !wake_cmd |=> comm_fail)
        else $error("sleep command not obeyed");
    a_wake_exit: assert property (wake_cmd |=> !comm_fail)
        else $error("wake command not obeyed");
    // Held request keeps its qualifiers, or the order of clears breaks
    a_req_hold: assert property (
        req_valid && !req_ready && !comm_fail |=> req_valid
        && $stable(req_addr) && $stable(req_write) && $stable(req_wdata))
        else $error("request changed");
    a_unsol_data: assert property (
        rsp_valid && rsp_unsol |-> rsp_data != 16'h0000
        && rsp_data[15:4] == 12'h000)
        else $error("unsolicited push carries bad status");
    a_unsol_pulse: assert property (rsp_unsol |-> rsp_valid)
        else $error("unsolicited mark without valid");
    a_recover_start: assert property (
        $rose(comm_fail) |-> ##[1:40] wake_cmd)
        else $error("no wake attempt after failure");
endmodule // cvfm_link_checker

// *** dv/cvfm_testbench.sv ***
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk, sys_rst, cmd_valid, cmd_write, cmd_ready, rd_valid;
    logic clear_faults, filt_reset, seq_ready, alert_valid, asleep;
    logic ov_detail_valid, recovering, scan_done, meas_done;
    logic osc_fault, par_fault;
    logic [2:0] tot_value;
    logic [3:0] cmd_addr, meas_cell;
    logic [11:0] ov_fault_flags, uv_fault_flags;
    logic [15:0] cmd_wdata, rd_data, alert_status, ov_detail;
    logic [15:0] fault_status, last_alert, last_ovd;
    logic [12*14-1:0] cell_value;
    int miscompares, check_count, alert_n;

    cvfm_link_if cvfm_link_if_i ();
    cvfm_device cvfm_device_i (.clk(clk), .sys_rst(sys_rst),
        .link(cvfm_link_if_i), .cell_value(cell_value),
        .scan_done(scan_done), .meas_done(meas_done),
        .meas_cell(meas_cell), .osc_fault(osc_fault),
        .par_fault(par_fault), .ov_fault_flags(ov_fault_flags),
        .uv_fault_flags(uv_fault_flags), .fault_status(fault_status),
        .asleep(asleep));
    cvfm_host cvfm_host_i (.clk(clk), .sys_rst(sys_rst),
        .link(cvfm_link_if_i), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
        .rd_valid(rd_valid), .rd_data(rd_data),
        .clear_faults(clear_faults), .filt_reset(filt_reset),
        .tot_value(tot_value), .seq_ready(seq_ready),
        .alert_valid(alert_valid), .alert_status(alert_status),
        .ov_detail_valid(ov_detail_valid), .ov_detail(ov_detail),
        .recovering(recovering));
    cvfm_link_checker cvfm_link_checker_i (.clk(clk), .sys_rst(sys_rst),
        .req_valid(cvfm_link_if_i.req_valid),
        .req_write(cvfm_link_if_i.req_write),
        .req_addr(cvfm_link_if_i.req_addr),
        .req_wdata(cvfm_link_if_i.req_wdata),
        .sleep_cmd(cvfm_link_if_i.sleep_cmd),
        .wake_cmd(cvfm_link_if_i.wake_cmd),
        .req_ready(cvfm_link_if_i.req_ready),
        .rsp_valid(cvfm_link_if_i.rsp_valid),
        .rsp_unsol(cvfm_link_if_i.rsp_unsol),
        .rsp_data(cvfm_link_if_i.rsp_data),
        .comm_fail(cvfm_link_if_i.comm_fail));

    always #50 clk = ~clk;

    // Pulses last one cycle; caught mid-cycle, clear of their edge
    always @(negedge clk) begin
        if (alert_valid === 1'b1) begin
            alert_n <= alert_n + 1;
            last_alert <= alert_status;
        end
        if (ov_detail_valid === 1'b1) begin
            last_ovd <= ov_detail;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: sig = cmd_ready;
            1: sig = rd_valid;
            2: sig = seq_ready;
            default: sig = !recovering;
        endcase
    endfunction

    // Bounded wait at falling edges; a hang ends the run
    task automatic wait_for(input int w);
        int n;
        n = 0;
        while (sig(w) !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 3000) begin
                miscompares++;
                $display("Error timeout on wait %0d", w);
                stop_test();
            end
        end
    endtask

    task automatic access(input logic wr, input logic [3:0] a,
        input logic [15:0] d);
        cmd_write = wr;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        #1 wait_for(0);
        @(negedge clk);
        cmd_valid = 1'b0;
        if (!wr) wait_for(1);
    endtask

    task automatic rdc(input string nm, input logic [3:0] a,
        input logic [15:0] e);
        access(1'b0, a, 16'h0000);
        check(nm, rd_data, e);
    endtask

    task automatic seq(input logic clr, input logic [2:0] t);
        clear_faults = clr;
        filt_reset = !clr;
        tot_value = t;
        #1 wait_for(2);
        @(negedge clk);
        clear_faults = 1'b0;
        filt_reset = 1'b0;
        repeat (2) @(negedge clk);
        wait_for(2);
        repeat (4) @(negedge clk);
    endtask

    task automatic pulse(input logic meas, input int k);
        repeat (k) begin
            @(negedge clk);
            scan_done = !meas;
            meas_done = meas;
            @(negedge clk);
            scan_done = 1'b0;
            meas_done = 1'b0;
        end
        repeat (6) @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {clk, cmd_valid, cmd_write, clear_faults, filt_reset} = 5'h00;
        {scan_done, meas_done, osc_fault, par_fault} = 4'h0;
        {cmd_addr, meas_cell, tot_value, cmd_wdata} = 27'h0;
        {last_alert, last_ovd} = 32'h0;
        cell_value = {12{14'h0C00}};
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        rdc("ov_limit", cvfm_pkg::ADDR_OV_LIMIT, 16'h1FFF);
        rdc("uv_limit", cvfm_pkg::ADDR_UV_LIMIT, 16'h0000);
        rdc("select", cvfm_pkg::ADDR_FAULT_SETUP, 16'h0003);
        rdc("cell_setup", cvfm_pkg::ADDR_CELL_SETUP, 16'h0000);
        for (int a = 4; a < 8; a++) rdc("flags", a[3:0], 16'h0000);
        $display("Test reset_values done");
        access(1'b1, cvfm_pkg::ADDR_OV_LIMIT, 16'h1000);
        access(1'b1, cvfm_pkg::ADDR_UV_LIMIT, 16'h0800);
        access(1'b1, cvfm_pkg::ADDR_CELL_SETUP, 16'h0002);
        rdc("ov_limit_w", cvfm_pkg::ADDR_OV_LIMIT, 16'h1000);
        cell_value[0+:14] = 14'h1001;
        cell_value[14+:14] = 14'h1FFF;
        cell_value[42+:14] = 14'h1000;
        cell_value[28+:14] = 14'h0800;
        pulse(1'b0, 7);
        cell_value[0+:14] = 14'h0C00;
        pulse(1'b0, 1);
        cell_value[0+:14] = 14'h1001;
        pulse(1'b0, 7);
        check("ov_run_broken", {4'h0, ov_fault_flags}, 16'h0000);
        pulse(1'b0, 1);
        check("ov_flags", {4'h0, ov_fault_flags}, 16'h0001);
        check("alert", last_alert, 16'h0001);
        check("ov_detail", last_ovd, 16'h0001);
        cell_value[28+:14] = 14'h07FF;
        cell_value[14+:14] = 14'h0000;
        pulse(1'b0, 8);
        check("uv_flags", {4'h0, uv_fault_flags}, 16'h0004);
        check("status", fault_status, 16'h0003);
        check("alert_count", alert_n[15:0], 16'h0001);
        seq(1'b1, 3'h0);
        rdc("ov_clr", cvfm_pkg::ADDR_OV_FAULT, 16'h0000);
        rdc("uv_clr", cvfm_pkg::ADDR_UV_FAULT, 16'h0000);
        rdc("st_clr", cvfm_pkg::ADDR_FAULT_STATUS, 16'h0000);
        $display("Test filter_and_clear done");
        for (int c = 0; c < 8; c++) begin
            seq(1'b1, 3'h0);
            seq(1'b0, c[2:0]);
            pulse(1'b0, (1 << c) - 1);
            check("ov_early", {4'h0, ov_fault_flags}, 16'h0000);
            pulse(1'b0, 1);
            check("ov_late", {4'h0, ov_fault_flags}, 16'h0001);
        end
        seq(1'b1, 3'h0);
        seq(1'b0, 3'h1);
        pulse(1'b0, 1);
        seq(1'b0, 3'h1);
        pulse(1'b0, 1);
        check("ov_reset", {4'h0, ov_fault_flags}, 16'h0000);
        pulse(1'b1, 2);
        check("ov_meas", {4'h0, ov_fault_flags}, 16'h0001);
        $display("Test sample_select done");
        seq(1'b1, 3'h0);
        @(negedge clk);
        osc_fault = 1'b1;
        @(negedge clk);
        check("osc_flag", fault_status, 16'h0004);
        check("osc_awake", {15'h0, asleep}, 16'h0000);
        @(negedge clk);
        check("osc_sleep", {15'h0, asleep}, 16'h0001);
        osc_fault = 1'b0;
        repeat (4) @(negedge clk);
        wait_for(3);
        check("woken", {15'h0, asleep}, 16'h0000);
        rdc("osc_status", cvfm_pkg::ADDR_FAULT_STATUS, 16'h0004);
        check("osc_alert", last_alert, 16'h0004);
        seq(1'b1, 3'h0);
        par_fault = 1'b1;
        @(negedge clk);
        par_fault = 1'b0;
        check("par_flag", fault_status, 16'h0008);
        $display("Test monitors done");
        stop_test();
    end
endmodule // testbench
